// ### lp_pkg.sv
// Package: register map, field layout and timing for the line printer block
// Notes on behaviour
// - After clear with nothing pending, status reads 0019.
// - Clear printer or clear interrupts while idle leaves status 0019.
// - Data interrupt selected with buffer open raises interrupt, status 001D.
// - Data select in same word as either clear still interrupts.
// - Done interrupt selected while idle raises nothing; status stays idle.
// - Alarm interrupt selected without alarm raises nothing.
// - Buffer takes 68 two-character words after clear without reject.
// - With 68 words loaded, data ready drops; status reads 0011.
// - A word offered while full is rejected, not stored.
// - Data interrupt held open gives one interrupt per slot, 68 total.
// - Legal characters start at code 20; words 2020 to 6060.
// - Fewer than 68 channel words keep data ready set.
// - Channel's 69th word is rejected, so it stops at first plus 68.
// - Character code 00 sets alarm; idle status then reads 0039.
// - Alarm with alarm interrupt selected interrupts, 003D; clear removes it.
// - After illegal character, alarm interrupt arrives but no done interrupt.
// - Print after illegal character completes and clears alarm; status 0019.
// - Print outputs the buffer, holds busy, then returns idle with data.
// - Clear interrupts during print is taken without reject.
// - After print the buffer again takes 68 words without reject.
// - Done interrupt selected before print is raised at print end.
// - Data interrupt selected during print rises when words are accepted.
// - Status bit 7 shows protect, bit 9 lines-per-inch select.
`default_nettype none
package lp_pkg;
    // AXI4-Lite byte offsets
    localparam logic [3:0] FUNC_OFS = 4'h0;
    localparam logic [3:0] DATA_OFS = 4'h4;
    localparam logic [3:0] STAT_OFS = 4'h8;
    localparam logic [3:0] COUNT_OFS = 4'hc;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    // Line buffer
    localparam int BUF_WORDS = 68;
    localparam logic [6:0] BUF_LAST = 7'h43;
    localparam logic [6:0] BUF_FULL = 7'h44;
    localparam logic [7:0] CHAR_MIN = 8'h20;
    localparam logic [7:0] CHAR_MAX = 8'h7f;
    // Print line time
    localparam int CLK_NS = 5;
    localparam int PRINT_US = 60;
    localparam int PRINT_CYCLES = PRINT_US * 1000 / CLK_NS;
    localparam logic [15:0] STAT_RST = 16'h0019;

    // Function word, low bits of a write to FUNC_OFS
    typedef struct packed {
        logic print;
        logic sel_alarm;
        logic sel_done;
        logic sel_data;
        logic clr_int;
        logic clr_prn;
    } func_t;

    // Status word
    typedef struct packed {
        logic [5:0] rsv_hi;
        logic lpi;
        logic rsv8;
        logic protect;
        logic rsv6;
        logic alarm;
        logic operation_done;
        logic data_ready;
        logic intr;
        logic busy;
        logic ready;
    } status_t;

    typedef enum logic [1:0] {
        PS_IDLE = 2'b00,
        PS_SEND = 2'b01,
        PS_WAIT = 2'b11
    } prn_state_t;

    function automatic logic char_bad(input logic [7:0] c);
        return (c < CHAR_MIN) || (c > CHAR_MAX);
    endfunction
endpackage
`default_nettype wire

// ### line_printer_ctrl.sv
// Line printer controller: AXI4-Lite registers, line buffer and print timing
`timescale 1ns/1ps
`default_nettype none
module line_printer_ctrl
    import lp_pkg::*;
#(
    parameter int print_cycles = PRINT_CYCLES
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Buffered channel word input
    input wire logic chan_valid,
    input wire logic [15:0] chan_word,
    output logic chan_ready,
    output logic chan_reject,
    // Printer mechanism
    output logic [15:0] prn_word,
    output logic prn_strobe,
    input wire logic prn_alarm,
    input wire logic protect_sw,
    input wire logic lpi_sel,
    // Interrupt line to host
    output logic irq
);
    // Pin synchronisers
    logic [2:0] pin_s1_q, pin_s2_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_s1_q <= 3'h0;
            pin_s2_q <= 3'h0;
        end else begin
            pin_s1_q <= {lpi_sel, protect_sw, prn_alarm};
            pin_s2_q <= pin_s1_q;
        end
    end
    logic ext_alarm, protect, lpi;
    assign ext_alarm = pin_s2_q[0];
    assign protect = pin_s2_q[1];
    assign lpi = pin_s2_q[2];

    // State declarations
    logic [15:0] buf_q [BUF_WORDS];
    logic [6:0] count_q;
    logic [6:0] rd_idx_q;
    logic [15:0] timer_q;
    prn_state_t state_q;
    logic char_alarm_q;
    logic sel_data_q, sel_done_q, sel_alarm_q;
    logic done_flag_q;
    logic [15:0] prn_word_q;
    logic prn_strobe_q;

    // Derived status
    logic busy, full, data_ready, alarm, intr, print_end;
    assign busy = (state_q != PS_IDLE);
    assign full = (count_q == BUF_FULL);
    // True for the last stored word of a drain
    function automatic logic last_word(input logic [6:0] idx,
                                       input logic [6:0] cnt);
        return (idx + 7'h01) >= cnt;
    endfunction
    logic draining, drain_last;
    assign draining = (state_q == PS_SEND);
    assign drain_last = draining && last_word(rd_idx_q, count_q);
    // Buffer is open again once it has been drained to the mechanism
    assign data_ready = !full && !draining;
    assign alarm = char_alarm_q || ext_alarm;
    assign print_end = (state_q == PS_WAIT) &&
                       (timer_q == 16'(print_cycles - 1));
    // Done interrupt only from a finished print, never from idle
    assign intr = (sel_data_q && data_ready) ||
                  (sel_alarm_q && alarm) || done_flag_q;

    status_t status;
    always_comb begin
        status = '0;
        status.ready = !ext_alarm;
        status.busy = busy;
        status.intr = intr;
        status.data_ready = data_ready;
        status.operation_done = !busy;
        status.alarm = alarm;
        status.protect = protect;
        status.lpi = lpi;
    end

    // AXI write channel capture, address and data in either order
    logic aw_have_q, w_have_q;
    logic [3:0] aw_addr_q;
    logic [15:0] w_data_q;
    logic w_lo_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    assign s_axi_awready = !aw_have_q && !bvalid_q;
    assign s_axi_wready = !w_have_q && !bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= 4'h0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (aw_have_q && w_have_q) begin
            aw_have_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have_q <= 1'b0;
            w_data_q <= 16'h0000;
            w_lo_q <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata[15:0];
            w_lo_q <= s_axi_wstrb[0] && s_axi_wstrb[1];
        end else if (aw_have_q && w_have_q) begin
            w_have_q <= 1'b0;
        end
    end

    // Write execution, in the same cycle that both halves are held
    logic wr_go, wr_func, wr_data, func_bad, data_bad;
    func_t fn;
    assign wr_go = aw_have_q && w_have_q;
    assign fn = func_t'(w_data_q[5:0]);
    // Clear printer and print are refused while the line is printing
    assign func_bad = busy && (fn.clr_prn || fn.print);
    assign data_bad = full || draining;
    assign wr_func = wr_go && w_lo_q && (aw_addr_q == FUNC_OFS) && !func_bad;
    assign wr_data = wr_go && w_lo_q && (aw_addr_q == DATA_OFS) && !data_bad;

    // Writes to read-only words answer OKAY and change nothing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            unique case (aw_addr_q)
                FUNC_OFS: begin
                    bresp_q <= func_bad ? RESP_SLVERR : RESP_OKAY;
                end
                DATA_OFS: begin
                    bresp_q <= data_bad ? RESP_SLVERR : RESP_OKAY;
                end
                STAT_OFS, COUNT_OFS: begin
                    bresp_q <= RESP_OKAY;
                end
                default: begin
                    bresp_q <= RESP_DECERR;
                end
            endcase
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Word source: bus write wins over the channel in the same cycle
    logic chan_take, chan_ok, word_in;
    logic [15:0] word_val;
    // Stall keeps a channel word from racing a clear or a print start
    assign chan_ready = !wr_go;
    assign chan_take = chan_valid && chan_ready;
    assign chan_reject = chan_take && data_bad;
    assign chan_ok = chan_take && !data_bad;
    assign word_in = wr_data || chan_ok;
    assign word_val = wr_data ? w_data_q : chan_word;

    logic clr_prn, print_go;
    assign clr_prn = wr_func && fn.clr_prn;
    assign print_go = wr_func && fn.print;

    // Line buffer and word count
    always_ff @(posedge aclk) begin
        if (word_in) begin
            buf_q[count_q] <= word_val;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_q <= 7'h00;
        end else if (clr_prn) begin
            count_q <= 7'h00;
        end else if (drain_last) begin
            count_q <= 7'h00;
        end else if (word_in) begin
            count_q <= count_q + 7'h01;
        end
    end

    // Illegal character alarm
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            char_alarm_q <= 1'b0;
        end else if (word_in && (char_bad(word_val[15:8]) ||
                                 char_bad(word_val[7:0]))) begin
            char_alarm_q <= 1'b1;
        end else if (clr_prn || print_go) begin
            char_alarm_q <= 1'b0;
        end
    end

    // Interrupt selections; a clear in the same word loses to a select
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sel_data_q <= 1'b0;
            sel_done_q <= 1'b0;
            sel_alarm_q <= 1'b0;
        end else if (wr_func) begin
            if (fn.clr_int || fn.clr_prn) begin
                sel_data_q <= fn.sel_data;
                sel_done_q <= fn.sel_done;
                sel_alarm_q <= fn.sel_alarm;
            end else begin
                sel_data_q <= sel_data_q || fn.sel_data;
                sel_done_q <= sel_done_q || fn.sel_done;
                sel_alarm_q <= sel_alarm_q || fn.sel_alarm;
            end
        end
    end

    // Done interrupt flag: print end sets, clears lose to it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done_flag_q <= 1'b0;
        end else if (print_end && sel_done_q) begin
            done_flag_q <= 1'b1;
        end else if (wr_func && (fn.clr_int || fn.clr_prn)) begin
            done_flag_q <= 1'b0;
        end
    end

    // Print sequencer: drain buffer to mechanism, then hold line time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= PS_IDLE;
            rd_idx_q <= 7'h00;
            timer_q <= 16'h0000;
        end else begin
            unique case (state_q)
                PS_IDLE: begin
                    rd_idx_q <= 7'h00;
                    timer_q <= 16'h0000;
                    if (print_go) begin
                        state_q <= (count_q == 7'h00) ? PS_WAIT : PS_SEND;
                    end
                end
                PS_SEND: begin
                    if (drain_last) begin
                        state_q <= PS_WAIT;
                    end
                    rd_idx_q <= rd_idx_q + 7'h01;
                end
                PS_WAIT: begin
                    timer_q <= timer_q + 16'h0001;
                    if (print_end) begin
                        state_q <= PS_IDLE;
                    end
                end
                default: begin
                    state_q <= PS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prn_word_q <= 16'h0000;
            prn_strobe_q <= 1'b0;
        end else begin
            prn_strobe_q <= draining;
            if (draining && rd_idx_q <= BUF_LAST) begin
                prn_word_q <= buf_q[rd_idx_q];
            end
        end
    end
    assign prn_word = prn_word_q;
    assign prn_strobe = prn_strobe_q;

    // Registered so the host line never glitches
    logic irq_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= intr;
        end
    end
    assign irq = irq_q;

    // AXI read channel; status is taken at the address handshake
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rresp_q <= RESP_OKAY;
            unique case (s_axi_araddr)
                FUNC_OFS: begin
                    rdata_q <= {26'h0, 1'b0, sel_alarm_q, sel_done_q,
                                sel_data_q, 2'h0};
                end
                DATA_OFS: begin
                    rdata_q <= 32'h0000_0000;
                end
                STAT_OFS: begin
                    rdata_q <= {16'h0000, status};
                end
                COUNT_OFS: begin
                    rdata_q <= {25'h0, count_q};
                end
                default: begin
                    rdata_q <= 32'h0000_0000;
                    rresp_q <= RESP_DECERR;
                end
            endcase
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### lp_chan_src.sv
// Buffered channel model: offers a run of words, stops on reject
`timescale 1ns/1ps
`default_nettype none
module lp_chan_src (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bench control
    input wire logic go,
    input wire logic [7:0] n_req,
    output logic busy,
    output logic [7:0] n_ok,
    // Channel side
    output logic chan_valid,
    output logic [15:0] chan_word,
    input wire logic chan_ready,
    input wire logic chan_reject
);
    logic run_q;
    logic [7:0] idx_q;
    logic [15:0] word_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_q <= 1'b0;
            idx_q <= 8'h00;
            word_q <= 16'h0000;
        end else if (go && !run_q) begin
            run_q <= 1'b1;
            idx_q <= 8'h00;
            word_q <= 16'h2020;
        end else if (run_q && chan_ready) begin
            if (chan_reject || idx_q + 8'h01 == n_req) begin
                run_q <= 1'b0;
                word_q <= ~word_q;
            end else begin
                word_q <= word_q + 16'h0001;
            end
            if (!chan_reject) begin
                idx_q <= idx_q + 8'h01;
            end
        end
    end
    assign chan_valid = run_q;
    assign chan_word = word_q;
    assign busy = run_q;
    assign n_ok = idx_q;
endmodule
`default_nettype wire

// ### lp_checker.sv
// Port timing checker for the line printer controller
`timescale 1ns/1ps
`default_nettype none
module lp_checker
    import lp_pkg::*;
#(
    parameter int print_cycles = PRINT_CYCLES
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // Channel and outputs
    input wire logic chan_valid,
    input wire logic chan_ready,
    input wire logic chan_reject,
    input wire logic prn_strobe,
    input wire logic irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_bresp_hold:
        assert property (s_axi_bvalid && !s_axi_bready |=>
            s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    chk_rdata_hold:
        assert property (s_axi_rvalid && !s_axi_rready |=>
            s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    chk_read_lat:
        assert property (s_axi_arvalid && s_axi_arready |=>
            s_axi_rvalid && !s_axi_arready)
        else $error("read answer not one cycle later");
    chk_write_lat:
        assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
            && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write answer not two cycles later");
    chk_write_block:
        assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("new write taken while answer pending");
    chk_bvalid_clear:
        assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer not cleared");
    chk_chan_reject:
        assert property (chan_reject |-> chan_valid && chan_ready)
        else $error("reject without a channel word");
    chk_reset_quiet:
        assert property ($rose(aresetn) |->
            !s_axi_bvalid && !s_axi_rvalid && !irq && !prn_strobe)
        else $error("outputs active after reset");
endmodule
`default_nettype wire

// ### line_printer_ctrl_bench.sv
// Self-checking bench for the line printer controller
`timescale 1ns/1ps
`default_nettype none
module line_printer_ctrl_bench
    import lp_pkg::*;
;
    logic aclk, aresetn, go, src_busy, prn_alarm, protect_sw, lpi_sel;
    logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, irq, prn_strobe;
    logic [31:0] s_axi_wdata, s_axi_rdata, st;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic chan_valid, chan_ready, chan_reject;
    logic [15:0] chan_word, prn_word;
    logic [7:0] n_req, n_ok;
    logic [15:0] exp_q[$], got_q[$];
    logic [5:0] fn_v[7] = '{6'h01, 6'h02, 6'h04, 6'h06, 6'h05, 6'h08, 6'h10};
    int errors, n_checks, seed;
    line_printer_ctrl #(.print_cycles(20)) line_printer_ctrl_inst (.*);
    lp_chan_src lp_chan_src_inst (.aclk, .aresetn, .go, .n_req,
        .busy(src_busy), .n_ok, .chan_valid, .chan_word, .chan_ready,
        .chan_reject);
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        if (prn_strobe === 1'b1) got_q.push_back(prn_word);
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        st = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic func(input logic [5:0] v);
        wr(FUNC_OFS, {26'h0, v});
    endtask
    task automatic stat(input logic [31:0] exp);
        rd(STAT_OFS);
        chk(st, exp);
        chk(resp, RESP_OKAY);
    endtask
    task automatic wait_idle;
        do begin
            rd(STAT_OFS);
        end while (st[1] !== 1'b0);
    endtask
    task automatic load(input int n, input logic want_irq);
        logic [15:0] w;
        for (int i = 0; i < n; i++) begin
            w[15:8] = 8'h20 + 8'({$random(seed)} % 65);
            w[7:0] = 8'h20 + 8'({$random(seed)} % 65);
            if (want_irq) chk(irq, 1'b1);
            wr(DATA_OFS, {16'h0000, w});
            chk(resp, RESP_OKAY);
            exp_q.push_back(w);
        end
    endtask
    task automatic run_chan(input logic [7:0] n);
        @(posedge aclk);
        n_req <= n;
        go <= 1'b1;
        @(posedge aclk);
        go <= 1'b0;
        do begin
            @(posedge aclk);
        end while (src_busy);
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        errors++;
        close_out();
    end
    initial begin
        seed = 32'ha083221f;
        {aresetn, go, prn_alarm, protect_sw, lpi_sel} = 5'h00;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 12'h00f;
        s_axi_wdata = 32'h0;
        n_req = 8'h00;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        stat(32'h19);
        {prn_alarm, protect_sw, lpi_sel} <= 3'h7;
        repeat (4) @(posedge aclk);
        stat(32'h2b8);
        {prn_alarm, protect_sw, lpi_sel} <= 3'h0;
        repeat (4) @(posedge aclk);
        foreach (fn_v[i]) begin
            func(6'h01);
            func(fn_v[i]);
            repeat (2) @(posedge aclk);
            chk(irq, fn_v[i][2]);
            stat(fn_v[i][2] ? 32'h1d : 32'h19);
        end
        $display("static status test done");
        func(6'h05);
        repeat (2) @(posedge aclk);
        load(68, 1'b1);
        repeat (2) @(posedge aclk);
        chk(irq, 1'b0);
        stat(32'h11);
        wr(DATA_OFS, 32'h2020);
        chk(resp, RESP_SLVERR);
        rd(COUNT_OFS);
        chk(st, 32'd68);
        $display("buffer fill test done");
        func(6'h09);
        exp_q.delete();
        got_q.delete();
        load(32, 1'b0);
        func(6'h20);
        wait_idle();
        chk(got_q.size(), exp_q.size());
        foreach (exp_q[i]) chk(got_q[i], exp_q[i]);
        stat(32'h1d);
        chk(irq, 1'b1);
        func(6'h01);
        load(32, 1'b0);
        func(6'h20);
        func(6'h01);
        chk(resp, RESP_SLVERR);
        func(6'h06);
        chk(resp, RESP_OKAY);
        wait_idle();
        stat(32'h1d);
        func(6'h02);
        load(68, 1'b0);
        stat(32'h11);
        $display("print test done");
        func(6'h01);
        wr(DATA_OFS, 32'h0020);
        stat(32'h39);
        func(6'h1a);
        stat(32'h3d);
        chk(irq, 1'b1);
        rd(FUNC_OFS);
        chk(st, 32'h18);
        func(6'h01);
        repeat (2) @(posedge aclk);
        chk(irq, 1'b0);
        stat(32'h19);
        rd(COUNT_OFS);
        chk(st, 32'd0);
        wr(DATA_OFS, 32'h0020);
        func(6'h20);
        wait_idle();
        stat(32'h19);
        $display("alarm test done");
        func(6'h01);
        run_chan(8'd67);
        chk(n_ok, 32'd67);
        stat(32'h19);
        func(6'h01);
        run_chan(8'd69);
        chk(n_ok, 32'd68);
        stat(32'h11);
        $display("channel test done");
        close_out();
    end
endmodule
bind line_printer_ctrl lp_checker #(.print_cycles(print_cycles))
    lp_checker_inst (.*);
`default_nettype wire
